// [smt_defines.svh]
// timing, codes and field positions for the drive command block
`ifndef SMT_DEFINES_SVH
`define SMT_DEFINES_SVH
// task-file register selects
`define SMT_SEL_FEAT 3'h1
`define SMT_SEL_CNT 3'h2
`define SMT_SEL_CYLL 3'h4
`define SMT_SEL_CYLH 3'h5
`define SMT_SEL_DEVH 3'h6
`define SMT_SEL_CMD 3'h7
// opcodes
`define SMT_OP_SLEEP_A 8'he6
`define SMT_OP_SLEEP_B 8'h99
`define SMT_OP_REL 8'hb0
`define SMT_KEY_LO 8'h4f
`define SMT_KEY_HI 8'hc2
// subcommands
`define SMT_SUB_RDVAL 8'hd0
`define SMT_SUB_RDTHR 8'hd1
`define SMT_SUB_ASAVE 8'hd2
`define SMT_SUB_SAVE 8'hd3
`define SMT_SUB_OFFL 8'hd4
`define SMT_SUB_EN 8'hd8
`define SMT_SUB_DIS 8'hd9
`define SMT_AS_OFF 8'h00
`define SMT_AS_ON 8'hf1
// off-line collection status values
`define SMT_OFS_NEVER 8'h00
`define SMT_OFS_SEG 8'h01
`define SMT_OFS_ALL 8'h02
`define SMT_OFS_ABRT 8'h05
// status and error bit positions
`define SMT_ST_BSY 7
`define SMT_ST_RDY 6
`define SMT_ST_DSC 4
`define SMT_ST_DRQ 3
`define SMT_ST_ERR 0
`define SMT_ER_ABT 2
`define SMT_DEVH_DEV 4
// one sector of 16-bit words
`define SMT_XFER_WORDS 9'h100
// autosave spacing
`define SMT_AS_MIN 30
`define SMT_CLK_MHZ 10
`define SMT_AS_CYC (64'd60000000 * `SMT_AS_MIN * `SMT_CLK_MHZ)
`endif

// [smt_pkg.sv]
// types shared by both ends of the drive command link
package smt_pkg;
  typedef logic [2:0] smt_sel_t;
  typedef enum logic [2:0] {
    SMT_D_IDLE = 3'b000,
    SMT_D_FLUSH = 3'b001,
    SMT_D_SPIN = 3'b010,
    SMT_D_SLEEP = 3'b011,
    SMT_D_SAVE = 3'b100,
    SMT_D_BSYOFF = 3'b101,
    SMT_D_IRQ = 3'b110,
    SMT_D_XFER = 3'b111
  } smt_dev_state_e;
  typedef enum logic [2:0] {
    SMT_H_IDLE = 3'b000,
    SMT_H_WR = 3'b001,
    SMT_H_WAIT = 3'b010,
    SMT_H_RD = 3'b011,
    SMT_H_FIN = 3'b100
  } smt_host_state_e;
endpackage

// [smt_if.sv]
// task-file link between host controller and drive
`timescale 1ns/10ps
interface smt_if;
  import smt_pkg::*;
  logic wr_stb;
  smt_sel_t wr_sel;
  logic [7:0] wr_data;
  logic srst;
  logic [7:0] status;
  logic [7:0] error;
  logic intrq;
  logic rd_valid;
  logic [15:0] rd_data;
  logic rd_ready;
  modport dev (input wr_stb, wr_sel, wr_data, srst, rd_ready,
    output status, error, intrq, rd_valid, rd_data);
  modport host (output wr_stb, wr_sel, wr_data, srst, rd_ready,
    input status, error, intrq, rd_valid, rd_data);
endinterface

// [smt_buf.sv]
// two-entry valid/ready buffer
`timescale 1ns/10ps
module smt_buf #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] mem_r [2];
  logic wp_r, rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule // smt_buf

// [smt_dev.sv]
// drive end: sleep and reliability-monitoring command handling
// Functional notes
// - only the sleep opcodes enter sleep
// - flush cache, interrupt, then spin down, interface off
// - leave sleep only by soft or hard reset
// - already stopped spindle skips spin-down
// - host loads key pattern, device bit, opcode
// - features selects subcommand before opcode
// - read values: busy, save, drq, unbusy, interrupt
// - read thresholds: busy, fetch, drq, unbusy, interrupt
// - autosave at idle entry thirty minutes on
// - count 00 off, F1 on, else error
// - autosave control: busy, apply, unbusy, interrupt
// - save values now regardless of autosave
// - offline start: busy, start, unbusy, interrupt
// - new command aborts offline collection promptly
// - one segment per start, status 01/02
// - interrupted segment keeps pointer, status 05
// - no monitoring until enable; enable persists
// - disable stops all; later subcommands other than enable abort
// - disable keeps values; refresh after re-enable
`timescale 1ns/10ps
`include "smt_defines.svh"
module smt_dev import smt_pkg::*; #(
  parameter logic DEV_NUM = 1'b0,
  parameter logic [7:0] TOTAL_SEG = 8'h01,
  parameter logic [63:0] AS_CYC = `SMT_AS_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  smt_if.dev lnk,
  input wire logic nv_smart_en,
  input wire logic nv_autosave,
  output logic smart_en,
  output logic autosave_en,
  output logic flush_req,
  input wire logic flush_done,
  output logic spin_req,
  input wire logic spin_done,
  input wire logic spindle_stopped,
  output logic save_req,
  input wire logic save_done,
  input wire logic idle_entry,
  output logic thr_sel,
  output logic [7:0] word_idx,
  input wire logic [15:0] word_in,
  output logic offl_run,
  input wire logic seg_done,
  output logic [7:0] offl_status,
  output logic [7:0] seg_ptr,
  output logic asleep
);
  smt_dev_state_e st_r;
  logic [7:0] feat_r, cnt_r, cyll_r, cylh_r, devh_r;
  logic bsy_r, drq_r, err_r, abt_r, intrq_r, loaded_r;
  logic xfer_r, flush_r, spin_r, save_r, thr_r, smart_r, asave_r, run_r;
  logic [7:0] stat_off_r, segp_r;
  logic [8:0] pushed_r;
  logic [63:0] as_cnt_r;
  logic buf_in_ready, asleep_r;

  // host writes land only while the interface is alive and idle
  wire wr_ok = lnk.wr_stb && st_r != SMT_D_SLEEP && !bsy_r && !drq_r;
  // a command counts only when the device bit written earlier selects this drive
  wire cmd_wr = wr_ok && lnk.wr_sel == `SMT_SEL_CMD && devh_r[`SMT_DEVH_DEV] == DEV_NUM;
  wire [7:0] op = lnk.wr_data;
  wire is_sleep = op == `SMT_OP_SLEEP_A || op == `SMT_OP_SLEEP_B;
  wire key_ok = cyll_r == `SMT_KEY_LO && cylh_r == `SMT_KEY_HI;
  wire is_rel = op == `SMT_OP_REL && key_ok;
  wire s_rdval = feat_r == `SMT_SUB_RDVAL;
  wire s_rdthr = feat_r == `SMT_SUB_RDTHR;
  wire s_asave = feat_r == `SMT_SUB_ASAVE;
  wire s_save = feat_r == `SMT_SUB_SAVE;
  wire s_offl = feat_r == `SMT_SUB_OFFL;
  wire s_en = feat_r == `SMT_SUB_EN;
  wire s_dis = feat_r == `SMT_SUB_DIS;
  wire s_known = s_rdval | s_rdthr | s_asave | s_save | s_offl | s_en | s_dis;
  wire as_bad = s_asave && cnt_r != `SMT_AS_OFF && cnt_r != `SMT_AS_ON;
  // disabled state refuses everything but enable, a repeated disable too
  wire rel_abort = !s_known || (!smart_r && !s_en) || as_bad;
  wire cmd_abort = cmd_wr && !is_sleep && (!is_rel || rel_abort);
  wire rel_go = cmd_wr && is_rel && !rel_abort;
  wire need_save = s_rdval || s_save;
  wire as_due = asave_r && smart_r && idle_entry && as_cnt_r >= AS_CYC;
  wire seg_last = (segp_r + 8'h01) >= TOTAL_SEG;
  wire buf_push = st_r == SMT_D_XFER && pushed_r != `SMT_XFER_WORDS;
  wire xfer_end = st_r == SMT_D_XFER && pushed_r == `SMT_XFER_WORDS && !lnk.rd_valid;

  smt_buf #(.W(16)) u_buf (
    .clk(clk),
    .sys_rst(sys_rst || lnk.srst),
    .in_valid(buf_push),
    .in_data(word_in),
    .in_ready(buf_in_ready),
    .out_valid(lnk.rd_valid),
    .out_data(lnk.rd_data),
    .out_ready(lnk.rd_ready)
  );

  assign lnk.status = {bsy_r, st_r != SMT_D_SLEEP, 1'b0, st_r != SMT_D_SLEEP,
    drq_r, 2'b00, err_r};
  assign lnk.error = {5'h00, abt_r, 2'b00};
  assign lnk.intrq = intrq_r;
  assign smart_en = smart_r;
  assign autosave_en = asave_r;
  assign flush_req = flush_r;
  assign spin_req = spin_r;
  assign save_req = save_r;
  assign thr_sel = thr_r;
  assign word_idx = pushed_r[7:0];
  assign offl_run = run_r;
  assign offl_status = stat_off_r;
  assign seg_ptr = segp_r;
  assign asleep = asleep_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      feat_r <= 8'h00;
      cnt_r <= 8'h00;
      cyll_r <= 8'h00;
      cylh_r <= 8'h00;
      devh_r <= 8'h00;
    end else if (wr_ok) begin
      case (lnk.wr_sel)
        `SMT_SEL_FEAT: feat_r <= lnk.wr_data;
        `SMT_SEL_CNT: cnt_r <= lnk.wr_data;
        `SMT_SEL_CYLL: cyll_r <= lnk.wr_data;
        `SMT_SEL_CYLH: cylh_r <= lnk.wr_data;
        `SMT_SEL_DEVH: devh_r <= lnk.wr_data;
        default: ;
      endcase
    end
  end

  // persistent enables are reloaded from storage one edge after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loaded_r <= 1'b0;
      smart_r <= 1'b0;
      asave_r <= 1'b0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      smart_r <= nv_smart_en;
      asave_r <= nv_autosave;
    end else if (rel_go && s_en) begin
      smart_r <= 1'b1;
    end else if (rel_go && s_dis) begin
      smart_r <= 1'b0;
      asave_r <= 1'b0;
    end else if (rel_go && s_asave) begin
      asave_r <= (cnt_r == `SMT_AS_ON);
    end
  end

  // offline collection runs beside the command path, never raising busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      stat_off_r <= `SMT_OFS_NEVER;
      segp_r <= 8'h00;
    end else if (run_r && cmd_wr) begin
      run_r <= 1'b0;
      stat_off_r <= `SMT_OFS_ABRT;
    end else if (st_r == SMT_D_SAVE && s_offl && !save_r) begin
      run_r <= 1'b1;
    end else if (run_r && seg_done) begin
      run_r <= 1'b0;
      segp_r <= segp_r + 8'h01;
      stat_off_r <= seg_last ? `SMT_OFS_ALL : `SMT_OFS_SEG;
    end
  end

  // the pin follows a flop, so it trails the state by one cycle
  always_ff @(posedge clk) begin
    if (sys_rst || lnk.srst) asleep_r <= 1'b0;
    else asleep_r <= (st_r == SMT_D_SLEEP);
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !asave_r || !smart_r || (save_r && save_done))
      as_cnt_r <= 64'h0;
    else if (as_cnt_r < AS_CYC)
      as_cnt_r <= as_cnt_r + 64'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst || lnk.srst) begin
      st_r <= SMT_D_IDLE;
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      abt_r <= 1'b0;
      intrq_r <= 1'b0;
      xfer_r <= 1'b0;
      flush_r <= 1'b0;
      spin_r <= 1'b0;
      save_r <= 1'b0;
      thr_r <= 1'b0;
      pushed_r <= 9'h000;
    end else begin
      if (wr_ok) intrq_r <= 1'b0;
      case (st_r)
        SMT_D_IDLE: begin
          if (cmd_abort) begin
            err_r <= 1'b1;
            abt_r <= 1'b1;
            intrq_r <= 1'b1;
          end else if (cmd_wr && is_sleep) begin
            err_r <= 1'b0;
            abt_r <= 1'b0;
            bsy_r <= 1'b1;
            flush_r <= 1'b1;
            st_r <= SMT_D_FLUSH;
          end else if (rel_go) begin
            err_r <= 1'b0;
            abt_r <= 1'b0;
            bsy_r <= 1'b1;
            save_r <= need_save && smart_r;
            xfer_r <= s_rdval || s_rdthr;
            thr_r <= s_rdthr;
            st_r <= SMT_D_SAVE;
          end else if (as_due && !save_r) begin
            save_r <= 1'b1;
          end else if (save_r && save_done) begin
            save_r <= 1'b0;
          end
        end
        SMT_D_FLUSH: begin
          if (flush_done) begin
            flush_r <= 1'b0;
            bsy_r <= 1'b0;
            intrq_r <= 1'b1;
            spin_r <= !spindle_stopped;
            st_r <= spindle_stopped ? SMT_D_SLEEP : SMT_D_SPIN;
          end
        end
        SMT_D_SPIN: begin
          if (spin_done) begin
            spin_r <= 1'b0;
            st_r <= SMT_D_SLEEP;
          end
        end
        SMT_D_SLEEP: ;
        SMT_D_SAVE: begin
          if (!save_r || save_done) begin
            save_r <= 1'b0;
            drq_r <= xfer_r;
            st_r <= SMT_D_BSYOFF;
          end
        end
        SMT_D_BSYOFF: begin
          bsy_r <= 1'b0;
          st_r <= SMT_D_IRQ;
        end
        SMT_D_IRQ: begin
          intrq_r <= 1'b1;
          pushed_r <= 9'h000;
          st_r <= xfer_r ? SMT_D_XFER : SMT_D_IDLE;
        end
        SMT_D_XFER: begin
          if (buf_push && buf_in_ready) pushed_r <= pushed_r + 9'h001;
          if (xfer_end) begin
            drq_r <= 1'b0;
            xfer_r <= 1'b0;
            st_r <= SMT_D_IDLE;
          end
        end
        default: st_r <= SMT_D_IDLE;
      endcase
    end
  end
endmodule // smt_dev

// [smt_host.sv]
// host end: issues sleep and reliability commands through the task file
`timescale 1ns/10ps
`include "smt_defines.svh"
module smt_host import smt_pkg::*; #(
  parameter logic DEV_NUM = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  smt_if.host lnk,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_feat,
  input wire logic [7:0] cmd_cnt,
  output logic cmd_ready,
  input wire logic soft_reset,
  output logic done,
  output logic [7:0] done_status,
  output logic [7:0] done_error,
  output logic rx_valid,
  output logic [15:0] rx_data,
  input wire logic rx_ready
);
  smt_host_state_e st_r;
  logic [2:0] step_r;
  logic [7:0] op_r, feat_r, cnt_r;
  logic [8:0] got_r;
  logic wr_stb_r, srst_r, done_r, rxv_r;
  logic [2:0] sel_r;
  logic [7:0] wd_r, dst_r, der_r;
  logic [15:0] rxd_r;
  // register order puts the subcommand ahead of the opcode
  wire [2:0] sel_nxt = step_r == 3'h0 ? `SMT_SEL_FEAT : step_r == 3'h1 ? `SMT_SEL_CNT
    : step_r == 3'h2 ? `SMT_SEL_CYLL : step_r == 3'h3 ? `SMT_SEL_CYLH
    : step_r == 3'h4 ? `SMT_SEL_DEVH : `SMT_SEL_CMD;
  wire [7:0] devh = {3'b101, DEV_NUM, 4'h0};
  wire [7:0] wd_nxt = step_r == 3'h0 ? feat_r : step_r == 3'h1 ? cnt_r
    : step_r == 3'h2 ? `SMT_KEY_LO : step_r == 3'h3 ? `SMT_KEY_HI
    : step_r == 3'h4 ? devh : op_r;
  wire take = st_r == SMT_H_RD && lnk.rd_valid && (!rxv_r || rx_ready);
  assign lnk.wr_stb = wr_stb_r;
  assign lnk.wr_sel = sel_r;
  assign lnk.wr_data = wd_r;
  assign lnk.srst = srst_r;
  assign lnk.rd_ready = st_r == SMT_H_RD && (!rxv_r || rx_ready);
  assign cmd_ready = st_r == SMT_H_IDLE && !srst_r;
  assign done = done_r;
  assign done_status = dst_r;
  assign done_error = der_r;
  assign rx_valid = rxv_r;
  assign rx_data = rxd_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= SMT_H_IDLE;
      step_r <= 3'h0;
      op_r <= 8'h00;
      feat_r <= 8'h00;
      cnt_r <= 8'h00;
      got_r <= 9'h000;
      wr_stb_r <= 1'b0;
      sel_r <= 3'h0;
      wd_r <= 8'h00;
      srst_r <= 1'b0;
      done_r <= 1'b0;
      dst_r <= 8'h00;
      der_r <= 8'h00;
      rxv_r <= 1'b0;
      rxd_r <= 16'h0000;
    end else begin
      wr_stb_r <= 1'b0;
      done_r <= 1'b0;
      srst_r <= 1'b0;
      if (rxv_r && rx_ready) rxv_r <= 1'b0;
      if (take) begin
        rxv_r <= 1'b1;
        rxd_r <= lnk.rd_data;
        got_r <= got_r + 9'h001;
      end
      case (st_r)
        SMT_H_IDLE: begin
          if (soft_reset) begin
            srst_r <= 1'b1;
          end else if (cmd_valid) begin
            op_r <= cmd_op;
            feat_r <= cmd_feat;
            cnt_r <= cmd_cnt;
            step_r <= 3'h0;
            st_r <= SMT_H_WR;
          end
        end
        SMT_H_WR: begin
          wr_stb_r <= 1'b1;
          sel_r <= sel_nxt;
          wd_r <= wd_nxt;
          step_r <= step_r + 3'h1;
          if (step_r == 3'h5) st_r <= SMT_H_WAIT;
        end
        SMT_H_WAIT: begin
          // the strobe just issued clears a stale interrupt on this edge
          if (lnk.intrq && !wr_stb_r) begin
            got_r <= 9'h000;
            st_r <= lnk.status[`SMT_ST_DRQ] ? SMT_H_RD : SMT_H_FIN;
          end
        end
        SMT_H_RD: begin
          if (take && got_r == `SMT_XFER_WORDS - 9'h001) st_r <= SMT_H_FIN;
        end
        SMT_H_FIN: begin
          done_r <= 1'b1;
          dst_r <= lnk.status;
          der_r <= lnk.error;
          st_r <= SMT_H_IDLE;
        end
        default: st_r <= SMT_H_IDLE;
      endcase
    end
  end
endmodule // smt_host

// [smt_asserts.sv]
// concurrent checks on the task-file link between host and drive
`timescale 1ns/10ps
`include "smt_defines.svh"
module smt_asserts import smt_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_stb,
  input wire smt_sel_t wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic srst,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic intrq,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_ready
);
  logic cmd_wr;
  assign cmd_wr = wr_stb && wr_sel == `SMT_SEL_CMD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_abort_has_flag: assert property (status[`SMT_ST_ERR] |-> error[`SMT_ER_ABT])
    else $error("error status without abort bit");
  a_no_data_err: assert property (status[`SMT_ST_ERR] |-> !status[`SMT_ST_DRQ] && !rd_valid)
    else $error("data offered on an aborted command");
  a_busy_from_cmd: assert property ($rose(status[`SMT_ST_BSY]) |-> $past(cmd_wr))
    else $error("busy raised without a command write");
  a_drq_order: assert property ($rose(status[`SMT_ST_DRQ]) |-> status[`SMT_ST_BSY] ##1
    (!status[`SMT_ST_BSY] && !intrq) ##1 intrq)
    else $error("data request, busy and interrupt out of order");
  a_busy_bounded: assert property ($rose(status[`SMT_ST_BSY]) |-> ##[1:300] !status[`SMT_ST_BSY])
    else $error("busy never cleared");
  a_intrq_holds: assert property (intrq && !wr_stb && !srst |=> intrq)
    else $error("interrupt dropped without a host write");
  a_rd_holds: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stalled word changed or vanished");
  a_rd_in_drq: assert property (rd_valid |-> status[`SMT_ST_DRQ])
    else $error("word offered outside data request");
  a_sleep_after_irq: assert property ($fell(status[`SMT_ST_RDY]) |-> intrq)
    else $error("interface went inactive before the interrupt");
  // a hard reset wakes the drive as well; its release is the first enabled edge
  a_wake_by_reset: assert property ($rose(status[`SMT_ST_RDY]) |->
    $past(srst) || $past(srst, 2) || $past(sys_rst))
    else $error("left sleep without a reset");
endmodule // smt_asserts

// [drive_sleep_and_smart_commands_test.sv]
// self-checking bench: host and drive ends joined over the task-file link
`timescale 1ns/10ps
`include "smt_defines.svh"
module drive_sleep_and_smart_commands_test import smt_pkg::*;;
  logic clk = 1'b0, sys_rst = 1'b1, nv_smart_en = 1'b0, nv_autosave = 1'b0;
  logic cmd_valid = 1'b0, soft_reset = 1'b0, rx_ready = 1'b0, idle_entry = 1'b0;
  logic flush_done = 1'b0, spin_done = 1'b0, save_done = 1'b0, spindle_stopped = 1'b0;
  logic seg_done = 1'b0;
  logic [7:0] cmd_op = 8'h00, cmd_feat = 8'h00, cmd_cnt = 8'h00;
  logic cmd_ready, done, rx_valid, smart_en, autosave_en, flush_req, spin_req, save_req;
  logic thr_sel, offl_run, asleep;
  logic [7:0] done_status, done_error, word_idx, offl_status, seg_ptr, f;
  logic [15:0] rx_data, word_in;
  logic [31:0] seed = 32'h5218;
  logic [2:0] stall = 3'h0;
  logic [7:0] as_cnt [6] = '{8'h00, 8'hf1, 8'h05, 8'h00, 8'h7e, 8'hf1};
  logic [5:0] as_err = 6'b010100, as_en = 6'b100110;
  int mismatches = 0, checked = 0, saves = 0, spins = 0, flushes = 0, i, s, f0;
  always #50 clk = ~clk;
  function automatic logic [15:0] word_exp(input logic thr, input logic [7:0] idx);
    return {thr, 7'h2a, idx} ^ 16'h5a00;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // stored sectors answer at once; the word lookup must be combinational
  assign word_in = word_exp(thr_sel, word_idx);
  // mechanics answer one cycle after each request; the reader stalls one cycle in eight
  always @(negedge clk) begin
    flush_done <= flush_req && !flush_done;
    spin_done <= spin_req && !spin_done;
    save_done <= save_req && !save_done;
    if (flush_req && !flush_done) flushes++;
    if (spin_req && !spin_done) spins++;
    if (save_req && !save_done) saves++;
    stall <= stall + 3'h1;
    rx_ready <= stall != 3'h5;
  end
  smt_if lnk_i();
  smt_host smt_host_inst (.clk(clk), .sys_rst(sys_rst), .lnk(lnk_i), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_feat(cmd_feat), .cmd_cnt(cmd_cnt), .cmd_ready(cmd_ready),
    .soft_reset(soft_reset), .done(done), .done_status(done_status),
    .done_error(done_error), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));
  // short autosave spacing and two segments keep the run brief
  smt_dev #(.TOTAL_SEG(8'h02), .AS_CYC(64'd20)) smt_dev_inst (.clk(clk), .sys_rst(sys_rst),
    .lnk(lnk_i), .nv_smart_en(nv_smart_en), .nv_autosave(nv_autosave), .smart_en(smart_en),
    .autosave_en(autosave_en), .flush_req(flush_req), .flush_done(flush_done),
    .spin_req(spin_req), .spin_done(spin_done), .spindle_stopped(spindle_stopped),
    .save_req(save_req), .save_done(save_done), .idle_entry(idle_entry), .thr_sel(thr_sel),
    .word_idx(word_idx), .word_in(word_in), .offl_run(offl_run), .seg_done(seg_done),
    .offl_status(offl_status), .seg_ptr(seg_ptr), .asleep(asleep));
  smt_asserts smt_asserts_inst (.clk(clk), .sys_rst(sys_rst), .wr_stb(lnk_i.wr_stb),
    .wr_sel(lnk_i.wr_sel), .wr_data(lnk_i.wr_data), .srst(lnk_i.srst),
    .status(lnk_i.status), .error(lnk_i.error), .intrq(lnk_i.intrq),
    .rd_valid(lnk_i.rd_valid), .rd_data(lnk_i.rd_data), .rd_ready(lnk_i.rd_ready));
  task automatic print_verdict();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      $display("unexpected at %0t: %s", $time, msg);
      mismatches++;
    end
  endtask
  task automatic run_cmd(input logic [7:0] op, feat, cnt, input logic abt, input int words);
    int n;
    int k;
    n = 0;
    cmd_op = op;
    cmd_feat = feat;
    cmd_cnt = cnt;
    cmd_valid = 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 100);
    if (cmd_ready !== 1'b1) begin
      chk(1'b0, "host never ready");
      print_verdict();
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
        chk(rx_data === word_exp(feat == `SMT_SUB_RDTHR, n[7:0]), "read word");
        n++;
      end
      if (done === 1'b1) break;
    end
    if (k == 3000) begin
      chk(1'b0, "command never completed");
      print_verdict();
    end
    chk(done_error[`SMT_ER_ABT] === abt && done_status[`SMT_ST_ERR] === abt, "abort");
    chk(n == words, "word count");
    if (op != `SMT_OP_SLEEP_A && op != `SMT_OP_SLEEP_B)
      chk(asleep === 1'b0, "slept on other command");
    @(negedge clk);
  endtask
  task automatic smart(input logic [7:0] feat, cnt, input logic abt, input int words);
    run_cmd(`SMT_OP_REL, feat, cnt, abt, words);
  endtask
  task automatic pulse(ref logic sig, input int gap);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
    repeat (gap) @(negedge clk);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    smart(`SMT_SUB_RDVAL, 8'h00, 1'b1, 0);
    smart(`SMT_SUB_DIS, 8'h00, 1'b1, 0);
    smart(`SMT_SUB_EN, 8'h00, 1'b0, 0);
    smart(`SMT_SUB_EN, 8'h00, 1'b0, 0);
    chk(smart_en === 1'b1, "enable");
    run_cmd(8'h50, `SMT_SUB_DIS, 8'h00, 1'b1, 0);
    chk(smart_en === 1'b1, "foreign opcode acted as a subcommand");
    s = saves;
    smart(`SMT_SUB_RDVAL, 8'h00, 1'b0, 256);
    chk(saves == s + 1, "values not stored before read");
    smart(`SMT_SUB_RDTHR, 8'h00, 1'b0, 256);
    for (i = 0; i < 6; i++) begin
      smart(`SMT_SUB_ASAVE, as_cnt[i], as_err[i], 0);
      chk(autosave_en === as_en[i], "autosave state");
    end
    s = saves;
    smart(`SMT_SUB_SAVE, 8'h00, 1'b0, 0);
    pulse(idle_entry, 5);
    chk(saves == s + 1, "save missing or autosave too early");
    repeat (30) @(negedge clk);
    pulse(idle_entry, 5);
    chk(saves == s + 2, "autosave missing");
    smart(8'hd5, 8'h00, 1'b1, 0);
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      f = seed[7:0];
      if (!(f inside {8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd8, 8'hd9, 8'hda}))
        smart(f, seed[15:8], 1'b1, 0);
    end
    smart(`SMT_SUB_OFFL, 8'h00, 1'b0, 0);
    chk(offl_run === 1'b1, "collection not started");
    pulse(seg_done, 2);
    chk(seg_ptr === 8'h01 && offl_status === `SMT_OFS_SEG, "first segment");
    smart(`SMT_SUB_OFFL, 8'h00, 1'b0, 0);
    smart(`SMT_SUB_RDVAL, 8'h00, 1'b0, 256);
    chk(!offl_run && seg_ptr === 8'h01 && offl_status === `SMT_OFS_ABRT, "abort");
    smart(`SMT_SUB_OFFL, 8'h00, 1'b0, 0);
    pulse(seg_done, 2);
    chk(seg_ptr === 8'h02 && offl_status === `SMT_OFS_ALL, "last segment");
    smart(`SMT_SUB_DIS, 8'h00, 1'b0, 0);
    chk(smart_en === 1'b0 && autosave_en === 1'b0, "disable");
    smart(`SMT_SUB_DIS, 8'h00, 1'b1, 0);
    smart(`SMT_SUB_SAVE, 8'h00, 1'b1, 0);
    smart(`SMT_SUB_EN, 8'h00, 1'b0, 0);
    s = saves;
    smart(`SMT_SUB_RDVAL, 8'h00, 1'b0, 256);
    chk(saves == s + 1, "values not refreshed");
    f0 = flushes;
    s = spins;
    run_cmd(`SMT_OP_SLEEP_A, 8'h00, 8'h00, 1'b0, 0);
    repeat (4) @(negedge clk);
    chk(asleep === 1'b1 && flushes == f0 + 1 && spins == s + 1, "sleep entry");
    pulse(soft_reset, 4);
    chk(asleep === 1'b0, "soft reset wake");
    spindle_stopped = 1'b1;
    run_cmd(`SMT_OP_SLEEP_B, 8'h00, 8'h00, 1'b0, 0);
    repeat (4) @(negedge clk);
    chk(asleep === 1'b1 && spins == s + 1, "spin-down not skipped");
    pulse(sys_rst, 2);
    chk(asleep === 1'b0, "hard reset wake");
    print_verdict();
  end
endmodule // drive_sleep_and_smart_commands_test
